/* src/scc_consts.svh */
// constants for the serial clock configuration block
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_ADDR_W 8
`define SCC_DATA_W 32
`define SCC_OFS_CTRL 8'h00
`define SCC_OFS_GEN 8'h04
`define SCC_OFS_TXD 8'h08
`define SCC_OFS_RXD 8'h0C
`define SCC_OFS_STAT 8'h10
`define SCC_BIT_SRC 4
`define SCC_BIT_POL 2
`define SCC_BIT_RPH 1
`define SCC_BIT_TPH 0
`define SCC_RST_SRC 1'h0
`define SCC_RST_POL 1'h0
`define SCC_RST_RPH 1'h1
`define SCC_RST_TPH 1'h0
`define SCC_RELOAD_W 6
`define SCC_RST_RELOAD 6'h02
`define SCC_BIT_TRANSMIT_BUFFER_EMPTY 0
`define SCC_BIT_RXBF 1
`define SCC_BIT_BUSY 2
`define SCC_REF_HZ 125000000
`define SCC_SLOW_HZ 2000000
`define SCC_SLOW_DIV (`SCC_REF_HZ / `SCC_SLOW_HZ)
`define SCC_EDGES 16
`endif

/* src/scc_pkg.sv */
// types of the serial clock configuration block
package scc_pkg;
   typedef enum logic [0:0] {
      SCC_IDLE,
      SCC_SHIFT
   } scc_state_t;
endpackage

/* src/scc_clk_div.sv */
// reload down-counter that paces the serial clock edges
`include "scc_consts.svh"
module scc_clk_div #(
   parameter int RELOAD_W = `SCC_RELOAD_W
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_run,
   input wire logic i_src_en,
   input wire logic [RELOAD_W-1:0] i_reload,
   output logic o_tick
);
   logic [RELOAD_W-1:0] cnt_ff;
   logic [RELOAD_W-1:0] nxt_cnt;
   logic nxt_tick;
   wire logic expire = i_run && i_src_en && (cnt_ff == '0);

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      if (!i_run) begin
         nxt_cnt = i_reload;
      end else if (expire) begin
         nxt_cnt = i_reload;
         nxt_tick = 1'b1;
      end else if (i_src_en) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cnt_ff <= RELOAD_W'(`SCC_RST_RELOAD);
         o_tick <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         o_tick <= nxt_tick;
      end
   end
endmodule

/* src/scc_top.sv */
// serial clock configuration and byte shifter of the serial master
//
// The implementer's own choice: the plain strobed port.
`include "scc_consts.svh"
module scc_top #(
   parameter int SLOW_DIV = `SCC_SLOW_DIV
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic [`SCC_ADDR_W-1:0] i_addr,
   input wire logic [`SCC_DATA_W-1:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`SCC_DATA_W-1:0] o_rd_data,
   input wire logic i_serial_data_in,
   output logic o_serial_clock_pin,
   output logic o_serial_data_out,
   output logic o_transmit_buffer_empty,
   output logic o_busy
);
   // control and generator registers
   logic clock_source_select_ff;
   logic idle_clock_level_ff;
   logic receive_sample_phase_ff;
   logic transmit_launch_phase_ff;
   logic [`SCC_RELOAD_W-1:0] reload_ff;
   // transfer state
   scc_pkg::scc_state_t state_ff;
   scc_pkg::scc_state_t nxt_state;
   logic [3:0] edge_cnt_ff;
   logic sclk_ff;
   logic mosi_ff;
   logic [7:0] tx_shift_ff;
   logic [7:0] tx_hold_ff;
   logic transmit_buffer_empty_ff;
   logic [7:0] rx_shift_ff;
   logic [7:0] rx_pend_ff;
   logic rx_pend_vld_ff;
   logic [7:0] rx_data_ff;
   logic rxbf_ff;
   logic [`SCC_DATA_W-1:0] rdata_ff;
   // input synchroniser and slow-source prescaler
   logic din_s1_ff;
   logic din_s2_ff;
   logic din_s3_ff;
   logic din_ff;
   logic [7:0] slow_cnt_ff;
   logic slow_en_ff;
   logic tick;

   // address decode
   wire logic sel_ctrl = (i_addr == `SCC_OFS_CTRL);
   wire logic sel_gen = (i_addr == `SCC_OFS_GEN);
   wire logic sel_txd = (i_addr == `SCC_OFS_TXD);
   wire logic sel_rxd = (i_addr == `SCC_OFS_RXD);
   wire logic sel_stat = (i_addr == `SCC_OFS_STAT);
   wire logic wr_ctrl = i_wr && sel_ctrl;
   wire logic wr_gen = i_wr && sel_gen;
   wire logic wr_txd = i_wr && sel_txd;
   wire logic rd_rxd = i_rd && sel_rxd;

   wire logic use_slow = clock_source_select_ff && (reload_ff != '0);
   wire logic src_en = use_slow ? slow_en_ff : 1'b1;

   wire logic shifting = (state_ff == scc_pkg::SCC_SHIFT);
   wire logic last_edge = tick && (edge_cnt_ff == 4'(`SCC_EDGES - 1));
   // sample on odd edges when phase clear, even when set
   wire logic sample_now = tick && (edge_cnt_ff[0] == receive_sample_phase_ff);
   // launch on odd edges when phase set, interior even edges when clear
   wire logic launch_now = tick && (edge_cnt_ff[0] != transmit_launch_phase_ff) && !last_edge;
   wire logic [7:0] rx_next = sample_now ? {rx_shift_ff[6:0], din_ff} : rx_shift_ff;
   // start when idle, chain a pending byte at the end of one
   wire logic start_idle = wr_txd && !shifting;
   wire logic chain = last_edge && !transmit_buffer_empty_ff;
   wire logic load = start_idle || chain;
   wire logic [7:0] load_byte = start_idle ? i_wr_data[7:0] : tx_hold_ff;
   wire logic byte_done = last_edge;

   wire logic [`SCC_DATA_W-1:0] ctrl_word = {27'h0000000, clock_source_select_ff, 1'b0, idle_clock_level_ff,
                                             receive_sample_phase_ff, transmit_launch_phase_ff};
   wire logic [`SCC_DATA_W-1:0] gen_word = {26'h0000000, reload_ff};
   wire logic [`SCC_DATA_W-1:0] stat_word = {29'h00000000, shifting, rxbf_ff, transmit_buffer_empty_ff};
   wire logic [`SCC_DATA_W-1:0] rxd_word = {24'h000000, rx_data_ff};
   wire logic [`SCC_DATA_W-1:0] rd_mux = sel_ctrl ? ctrl_word :
                                         sel_gen ? gen_word :
                                         sel_rxd ? rxd_word :
                                         sel_stat ? stat_word : 32'h00000000;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         scc_pkg::SCC_IDLE: begin
            if (start_idle) begin
               nxt_state = scc_pkg::SCC_SHIFT;
            end
         end
         scc_pkg::SCC_SHIFT: begin
            if (last_edge && transmit_buffer_empty_ff) begin
               nxt_state = scc_pkg::SCC_IDLE;
            end
         end
         default: nxt_state = scc_pkg::SCC_IDLE;
      endcase
   end

   scc_clk_div #(
      .RELOAD_W(`SCC_RELOAD_W)
   ) u_div (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_run(shifting && !chain),
      .i_src_en(src_en),
      .i_reload(reload_ff),
      .o_tick(tick)
   );

   // 2 MHz enable; integer divisor so the slow rate is approximate
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         slow_cnt_ff <= 8'h00;
         slow_en_ff <= 1'b0;
      end else if (slow_cnt_ff == 8'(SLOW_DIV - 1)) begin
         slow_cnt_ff <= 8'h00;
         slow_en_ff <= 1'b1;
      end else begin
         slow_cnt_ff <= slow_cnt_ff + 8'h01;
         slow_en_ff <= 1'b0;
      end
   end

   // pin input: accepted only once stages two and three agree
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         din_s1_ff <= 1'b0;
         din_s2_ff <= 1'b0;
         din_s3_ff <= 1'b0;
         din_ff <= 1'b0;
      end else begin
         din_s1_ff <= i_serial_data_in;
         din_s2_ff <= din_s1_ff;
         din_s3_ff <= din_s2_ff;
         if (din_s2_ff == din_s3_ff) begin
            din_ff <= din_s3_ff;
         end
      end
   end

   // register writes, only defined bits stored
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         clock_source_select_ff <= `SCC_RST_SRC;
         idle_clock_level_ff <= `SCC_RST_POL;
         receive_sample_phase_ff <= `SCC_RST_RPH;
         transmit_launch_phase_ff <= `SCC_RST_TPH;
         reload_ff <= `SCC_RST_RELOAD;
      end else begin
         if (wr_ctrl) begin
            clock_source_select_ff <= i_wr_data[`SCC_BIT_SRC];
            idle_clock_level_ff <= i_wr_data[`SCC_BIT_POL];
            receive_sample_phase_ff <= i_wr_data[`SCC_BIT_RPH];
            transmit_launch_phase_ff <= i_wr_data[`SCC_BIT_TPH];
         end
         if (wr_gen) begin
            reload_ff <= i_wr_data[`SCC_RELOAD_W-1:0];
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= i_rd ? rd_mux : 32'h00000000;
      end
   end

   // clock idles at polarity level, toggles per tick
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_ff <= scc_pkg::SCC_IDLE;
         sclk_ff <= `SCC_RST_POL;
         edge_cnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         if (!shifting) begin
            sclk_ff <= idle_clock_level_ff;
            edge_cnt_ff <= 4'h0;
         end else if (tick) begin
            sclk_ff <= !sclk_ff;
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
         end
      end
   end

   // phase clear presents the first bit at load time
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         tx_shift_ff <= 8'h00;
         mosi_ff <= 1'b0;
      end else if (load) begin
         if (transmit_launch_phase_ff) begin
            tx_shift_ff <= load_byte;
         end else begin
            mosi_ff <= load_byte[7];
            tx_shift_ff <= {load_byte[6:0], 1'b0};
         end
      end else if (launch_now) begin
         mosi_ff <= tx_shift_ff[7];
         tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
      end
   end

   // buffer empty flag; a write while busy parks the byte
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         transmit_buffer_empty_ff <= 1'b1;
         tx_hold_ff <= 8'h00;
      end else if (wr_txd && shifting) begin
         transmit_buffer_empty_ff <= 1'b0;
         tx_hold_ff <= i_wr_data[7:0];
      end else if (chain) begin
         transmit_buffer_empty_ff <= 1'b1;
      end
   end

   // receive side: a new byte beats a read clearing the full flag
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rx_shift_ff <= 8'h00;
         rx_pend_ff <= 8'h00;
         rx_pend_vld_ff <= 1'b0;
         rx_data_ff <= 8'h00;
         rxbf_ff <= 1'b0;
      end else begin
         rx_shift_ff <= rx_next;
         if (byte_done && (!rxbf_ff || rd_rxd)) begin
            rx_data_ff <= rx_next;
            rxbf_ff <= 1'b1;
         end else if (byte_done) begin
            rx_pend_ff <= rx_next;
            rx_pend_vld_ff <= 1'b1;
         end else if (rd_rxd && rx_pend_vld_ff) begin
            rx_data_ff <= rx_pend_ff;
            rx_pend_vld_ff <= 1'b0;
         end else if (rd_rxd) begin
            rxbf_ff <= 1'b0;
         end
      end
   end

   assign o_rd_data = rdata_ff;
   assign o_serial_clock_pin = sclk_ff;
   assign o_serial_data_out = mosi_ff;
   assign o_transmit_buffer_empty = transmit_buffer_empty_ff;
   assign o_busy = state_ff == scc_pkg::SCC_SHIFT;

   sequence s_tick_gap2;
      !tick [*2] ##1 tick;
   endsequence

   sequence s_start_write;
      wr_txd && !shifting && transmit_buffer_empty_ff;
   endsequence

   AST_SRC_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (reload_ff == '0) |-> src_en)
      else $error("zero reload did not force the main clock");

   AST_SRC_SLOW: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (clock_source_select_ff && reload_ff != '0) |-> (src_en == slow_en_ff))
      else $error("slow source not used when selected");

   AST_IDLE_LEVEL: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (!o_busy && $past(!o_busy) && $stable(idle_clock_level_ff)) |-> (o_serial_clock_pin == idle_clock_level_ff))
      else $error("serial clock not at idle level");

   AST_RX_EDGE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      sample_now |-> (edge_cnt_ff[0] == receive_sample_phase_ff) &&
                     (sclk_ff == (edge_cnt_ff[0] ^ idle_clock_level_ff)))
      else $error("receive sample on wrong edge");

   AST_TX_LAUNCH: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      $changed(o_serial_data_out) |-> $past(launch_now || load))
      else $error("output data changed off a launch edge");

   AST_TX_FIRST: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (start_idle && !transmit_launch_phase_ff) |=> (o_serial_data_out == $past(i_wr_data[7])) && (edge_cnt_ff == 4'h0))
      else $error("first bit not presented before first edge");

   AST_RELOAD_RST: assert property (@(posedge i_ref_clk)
      i_srst |=> (reload_ff == `SCC_RST_RELOAD) && receive_sample_phase_ff && !clock_source_select_ff)
      else $error("reload value not reset to two");

   AST_DIV_PERIOD: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (tick && !last_edge && reload_ff == `SCC_RST_RELOAD && !use_slow && !wr_gen && !wr_ctrl) |=> s_tick_gap2)
      else $error("half period not reload plus one cycles");

   AST_TRANSMIT_BUFFER_EMPTY_START: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      s_start_write |=> o_busy && o_transmit_buffer_empty)
      else $error("transmit write did not start a byte");

   AST_RSVD: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (i_rd && sel_ctrl) |=> (o_rd_data[31:5] == 27'h0000000) && !o_rd_data[3])
      else $error("reserved control bits read nonzero");
endmodule

/* verification/scc_peer_model.sv */
// far side serial peripheral model
module scc_peer_model (
   input wire logic i_ref_clk,
   input wire logic i_busy,
   input wire logic i_clk_pin,
   input wire logic i_dout,
   input wire logic i_rph,
   input wire logic i_tph,
   input wire logic [7:0] i_tx,
   output logic o_din,
   output logic [7:0] o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev = 1'b0;
   logic was_busy = 1'b0;
   logic go = 1'b0;
   logic [4:0] n = 5'h00;
   logic [7:0] sh = 8'h00;
   // edge 16 arrives as busy drops, so gate edges by the busy seen one cycle before
   wire edg = was_busy && (i_clk_pin != prev);
   wire [4:0] k = n + 5'h01;
   initial o_din = 1'b0;
   initial o_rx = 8'h00;
   always @(posedge i_ref_clk) begin
      prev <= i_clk_pin;
      was_busy <= i_busy;
      if (edg) begin
         n <= (k == 5'h10) ? 5'h00 : k;
         if (k[0] != i_tph) o_rx <= {o_rx[6:0], i_dout};
         if (k[0] == i_rph && k != 5'h10) begin
            o_din <= sh[7];
            sh <= {sh[6:0], 1'b0};
         end
         if (k == 5'h10) begin
            go <= 1'b0;
            sh <= i_tx;
         end
      end else if (!i_busy) begin
         n <= 5'h00;
         go <= 1'b0;
         sh <= i_tx;
         // idle line keeps changing so stale data never passes
         o_din <= ~o_din;
      end else if (!go && !i_rph) begin
         go <= 1'b1;
         o_din <= sh[7];
         sh <= {sh[6:0], 1'b0};
      end
   end
endmodule

/* verification/scc_top_bench.sv */
// self-checking bench for the serial clock configuration block
module scc_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // small divider keeps the slow-source case short
   localparam int SDIV = 4;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wr_data = 32'h0;
   logic [31:0] o_rd_data;
   logic o_serial_clock_pin;
   logic o_serial_data_out;
   logic o_transmit_buffer_empty;
   logic o_busy;
   logic din;
   logic rph = 1'b1;
   logic tph = 1'b0;
   logic [7:0] ptx = 8'h00;
   logic [7:0] prx;
   logic [31:0] rv;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   always #4 i_ref_clk = ~i_ref_clk;
   scc_top #(.SLOW_DIV(SDIV)) DUT (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_addr(i_addr),
      .i_wr_data(i_wr_data),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rd_data(o_rd_data),
      .i_serial_data_in(din),
      .o_serial_clock_pin(o_serial_clock_pin),
      .o_serial_data_out(o_serial_data_out),
      .o_transmit_buffer_empty(o_transmit_buffer_empty),
      .o_busy(o_busy)
   );
   scc_peer_model peer (
      .i_ref_clk(i_ref_clk),
      .i_busy(o_busy),
      .i_clk_pin(o_serial_clock_pin),
      .i_dout(o_serial_data_out),
      .i_rph(rph),
      .i_tph(tph),
      .i_tx(ptx),
      .o_din(din),
      .o_rx(prx)
   );
   task automatic report_and_stop();
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      rv = o_rd_data;
   endtask
   task automatic wait_idle();
      @(posedge i_ref_clk);
      #1;
      while (o_busy !== 1'b0) begin
         @(posedge i_ref_clk);
         #1;
      end
   endtask
   task automatic xfer(input logic [31:0] ctl, input logic [5:0] rl, input int iv, input logic [7:0] b,
                       input logic chk_d);
      int k;
      logic pol;
      pol = ctl[2];
      rph = ctl[1];
      tph = ctl[0];
      ptx = ~b;
      wr(8'h00, ctl);
      wr(8'h04, {26'h0, rl});
      chk(o_serial_clock_pin, pol);
      wr(8'h08, {24'h0, b});
      chk(o_transmit_buffer_empty, 1'b1);
      chk(o_busy, 1'b1);
      while (o_serial_clock_pin === pol) begin
         @(posedge i_ref_clk);
         #1;
      end
      chk(o_serial_clock_pin, !pol);
      k = 0;
      while (o_serial_clock_pin === !pol) begin
         @(posedge i_ref_clk);
         #1;
         k++;
      end
      chk(32'(k), 32'(iv));
      wait_idle();
      chk(o_serial_clock_pin, pol);
      rd(8'h0C);
      if (chk_d) begin
         chk(prx, b);
         chk(rv, {24'h0, ~b});
      end
   endtask
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      rd(8'h00);
      chk(rv, 32'h2);
      rd(8'h04);
      chk(rv, 32'h2);
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00);
      chk(rv, 32'h17);
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04);
      chk(rv, 32'h3F);
      wr(8'h3C, 32'hFFFFFFFF);
      rd(8'h3C);
      chk(rv, 32'h0);
      for (int m = 0; m < 8; m++) begin
         xfer(32'(m), 6'(6 + m), 7 + m, 8'h5A + 8'(m * 17), 1'b1);
      end
      xfer(32'h0, 6'h02, 3, 8'hA5, 1'b0);
      xfer(32'h10, 6'h02, 3 * SDIV, 8'hC3, 1'b0);
      xfer(32'h10, 6'h00, 1, 8'h3C, 1'b0);
      rph = 1'b1;
      tph = 1'b0;
      ptx = 8'h96;
      wr(8'h00, 32'h2);
      wr(8'h04, 32'h6);
      wr(8'h08, 32'h81);
      wr(8'h08, 32'h7E);
      chk(o_transmit_buffer_empty, 1'b0);
      wait_idle();
      chk(o_transmit_buffer_empty, 1'b1);
      chk(prx, 8'h7E);
      rd(8'h0C);
      chk(rv, 32'h96);
      rd(8'h0C);
      chk(rv, 32'h96);
      report_and_stop();
   end
endmodule
